/* rtl/banked_regs_pkg.sv */
package banked_regs_pkg;
  // ************************************************************
  // Mode codes and status word fields
  // ************************************************************
  localparam logic [4:0] MODE_USER = 5'h10;
  localparam logic [4:0] MODE_FAST = 5'h11;
  localparam logic [4:0] MODE_NORM = 5'h12;
  localparam logic [4:0] MODE_SUPV = 5'h13;
  localparam logic [4:0] MODE_ABRT = 5'h17;
  localparam logic [4:0] MODE_UNDF = 5'h1B;
  localparam logic [4:0] MODE_SYST = 5'h1F;
  localparam int STATE_BIT = 5;
  localparam logic [31:0] STATUS_RST = 32'h0000_0013;
  localparam logic [31:0] PC_RST = 32'h0000_0000;
  localparam logic [2:0] SLOT_NONE = 3'h7;
  localparam int NUM_GP = 31;
  localparam int NUM_SAVED = 5;
  localparam logic [31:0] STEP_FULL = 32'h0000_0004;
  localparam logic [31:0] STEP_COMPACT = 32'h0000_0002;
  // ************************************************************
  // Register map (byte offsets)
  // ************************************************************
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_OPERAND = 8'h04;
  localparam logic [7:0] OFF_FETCH = 8'h08;
  localparam logic [7:0] OFF_INSN = 8'h0C;
  localparam logic [7:0] OFF_LANE_CTRL = 8'h10;
  localparam logic [7:0] OFF_LANE_DATA = 8'h14;
  localparam logic [7:0] OFF_LANE_BUS = 8'h18;
  localparam logic [7:0] OFF_CTRL = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_CUR_STATUS = 8'h28;
  localparam logic [7:0] OFF_SAVED_STATUS = 8'h2C;
  localparam logic [7:0] OFF_GPR_BASE = 8'h40;
  localparam logic [7:0] OFF_GPR_LAST = 8'h7C;
  // ************************************************************
  // Commands and bus answers
  // ************************************************************
  localparam logic [2:0] OP_BRANCH_LINK = 3'h1;
  localparam logic [2:0] OP_BRANCH_EXCHANGE = 3'h2;
  localparam logic [2:0] OP_EXC_ENTRY = 3'h3;
  localparam logic [2:0] OP_EXC_RETURN = 3'h4;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* rtl/banked_register_file.sv */
`timescale 1ns/1ps
// Functional notes
// - Two states: full-width 32-bit and compact 16-bit instructions.
// - Compact state picks the instruction halfword by program counter bit 1.
// - Changing execution state keeps mode and all register contents but the program counter.
// - Exceptions run full-width; return restores compact if it was active.
// - Memory is bytes from zero; bytes 0-3 first word, 4-7 next.
// - Big-endian puts byte 0 on data bits 31 to 24.
// - Little-endian puts byte 0 on data bits 7 to 0.
// - Seven modes exist in both states; all but user are privileged.
// - 37 physical 32-bit registers: 31 general, 6 status.
// - Sixteen general registers plus status visible, saved one if present.
// - Branch with link copies the program counter into register 14.
// - Exception entry writes return address into the entered mode's r14.
// - Entry saves prior status into saved status; privileged access only.
// - Fast interrupt mode banks indices 8 to 14 privately.
// - Supervisor, abort, interrupt, undefined modes bank indices 13 and 14.
// - System mode uses user registers unbanked yet is privileged.
// - Unbanked indices in privileged modes reach the shared user register.
// - Five-bit mode field codes user, fast, normal, supervisor, abort, undefined, system.
// - Status state bit set in compact state and mirrored on an output.
module banked_register_file (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic state_indicator_output
);
  // ************************************************************
  // Mode decoding
  // ************************************************************
  function automatic logic mode_ok(input logic [4:0] m);
    mode_ok = (m == banked_regs_pkg::MODE_USER) |
      (m == banked_regs_pkg::MODE_FAST) | (m == banked_regs_pkg::MODE_NORM) |
      (m == banked_regs_pkg::MODE_SUPV) | (m == banked_regs_pkg::MODE_ABRT) |
      (m == banked_regs_pkg::MODE_UNDF) | (m == banked_regs_pkg::MODE_SYST);
  endfunction

  function automatic logic [4:0] phys(input logic [4:0] m,
                                      input logic [3:0] i);
    logic [4:0] p;
    p = {1'b0, i};
    if (m == banked_regs_pkg::MODE_FAST && i >= 4'd8 && i <= 4'd14) begin
      p = 5'd8 + {1'b0, i};
    end else if (i == 4'd13 || i == 4'd14) begin
      if (m == banked_regs_pkg::MODE_SUPV) begin
        p = 5'd10 + {1'b0, i};
      end else if (m == banked_regs_pkg::MODE_ABRT) begin
        p = 5'd12 + {1'b0, i};
      end else if (m == banked_regs_pkg::MODE_NORM) begin
        p = 5'd14 + {1'b0, i};
      end else if (m == banked_regs_pkg::MODE_UNDF) begin
        p = 5'd16 + {1'b0, i};
      end
    end
    phys = p;
  endfunction

  function automatic logic [2:0] slot(input logic [4:0] m);
    slot = banked_regs_pkg::SLOT_NONE;
    if (m == banked_regs_pkg::MODE_FAST) begin
      slot = 3'd0;
    end else if (m == banked_regs_pkg::MODE_SUPV) begin
      slot = 3'd1;
    end else if (m == banked_regs_pkg::MODE_ABRT) begin
      slot = 3'd2;
    end else if (m == banked_regs_pkg::MODE_NORM) begin
      slot = 3'd3;
    end else if (m == banked_regs_pkg::MODE_UNDF) begin
      slot = 3'd4;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // Physical store: user r0-r15 at 0-15, banked copies at 16-30
  logic [31:0] gp_q [banked_regs_pkg::NUM_GP];
  logic [31:0] saved_q [banked_regs_pkg::NUM_SAVED];
  logic [31:0] cur_q;
  logic [31:0] operand_q, fetch_q, lane_data_q;
  logic [5:0] lane_ctrl_q;
  logic big_endian_q;
  logic [4:0] mode;
  logic t_bit, priv;
  logic [31:0] pc, step;
  logic [2:0] cur_slot;

  assign mode = cur_q[4:0];
  assign t_bit = cur_q[banked_regs_pkg::STATE_BIT];
  assign priv = (mode != banked_regs_pkg::MODE_USER);
  assign pc = gp_q[15];
  assign cur_slot = slot(mode);
  assign step = t_bit ? banked_regs_pkg::STEP_COMPACT :
    banked_regs_pkg::STEP_FULL;

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  logic aw_held_q, w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire, wr_hit, rd_hit;
  logic [31:0] rd_val;

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (clk_en) begin
      // Ready mirrors the holding flop in a register of its own, no glue
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= banked_regs_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? banked_regs_pkg::RESP_OKAY :
          banked_regs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= banked_regs_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? banked_regs_pkg::RESP_OKAY :
          banked_regs_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Instruction select and byte lanes
  // ************************************************************
  logic [31:0] insn, lane_bus;
  logic [1:0] lane_off, lane_size, lane_sh;
  logic misaligned;
  assign lane_off = lane_ctrl_q[1:0];
  assign lane_size = lane_ctrl_q[5:4];

  always_comb begin
    insn = fetch_q;
    if (t_bit) begin
      // Halfword order in the fetched word follows the byte order
      insn = (pc[1] ^ big_endian_q) ? {16'h0000, fetch_q[31:16]} :
        {16'h0000, fetch_q[15:0]};
    end
  end

  always_comb begin
    lane_sh = lane_off;
    if (big_endian_q) begin
      if (lane_size == banked_regs_pkg::SIZE_BYTE) begin
        lane_sh = 2'd3 - lane_off;
      end else if (lane_size == banked_regs_pkg::SIZE_HALF) begin
        lane_sh = {~lane_off[1], 1'b0};
      end else begin
        lane_sh = 2'd0;
      end
    end
    if (lane_size == banked_regs_pkg::SIZE_BYTE) begin
      lane_bus = {24'h00_0000, lane_data_q[7:0]} << {lane_sh, 3'b000};
    end else if (lane_size == banked_regs_pkg::SIZE_HALF) begin
      lane_bus = {16'h0000, lane_data_q[15:0]} << {lane_sh[1], 4'h0};
    end else begin
      lane_bus = lane_data_q;
    end
  end

  // Flags only; the access is still formed so software sees the damage
  assign misaligned = (lane_size == banked_regs_pkg::SIZE_WORD) ?
    (lane_off != 2'd0) : (lane_size == banked_regs_pkg::SIZE_HALF) ?
    lane_off[0] : 1'b0;

  // ************************************************************
  // Address decode
  // ************************************************************
  logic gpr_rd, gpr_wr;
  assign gpr_rd = s_axi_araddr >= banked_regs_pkg::OFF_GPR_BASE &&
    s_axi_araddr <= banked_regs_pkg::OFF_GPR_LAST;
  assign gpr_wr = awaddr_q >= banked_regs_pkg::OFF_GPR_BASE &&
    awaddr_q <= banked_regs_pkg::OFF_GPR_LAST;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == banked_regs_pkg::OFF_CMD) begin
      rd_val = 32'h0000_0000;
    end else if (s_axi_araddr == banked_regs_pkg::OFF_OPERAND) begin
      rd_val = operand_q;
    end else if (s_axi_araddr == banked_regs_pkg::OFF_FETCH) begin
      rd_val = fetch_q;
    end else if (s_axi_araddr == banked_regs_pkg::OFF_INSN) begin
      rd_val = insn;
    end else if (s_axi_araddr == banked_regs_pkg::OFF_LANE_CTRL) begin
      rd_val = {26'h000_0000, lane_ctrl_q};
    end else if (s_axi_araddr == banked_regs_pkg::OFF_LANE_DATA) begin
      rd_val = lane_data_q;
    end else if (s_axi_araddr == banked_regs_pkg::OFF_LANE_BUS) begin
      rd_val = lane_bus;
    end else if (s_axi_araddr == banked_regs_pkg::OFF_CTRL) begin
      rd_val = {31'h0000_0000, big_endian_q};
    end else if (s_axi_araddr == banked_regs_pkg::OFF_STATUS) begin
      rd_val = {29'h0000_0000, t_bit, priv, misaligned};
    end else if (s_axi_araddr == banked_regs_pkg::OFF_CUR_STATUS) begin
      rd_val = cur_q;
    end else if (s_axi_araddr == banked_regs_pkg::OFF_SAVED_STATUS) begin
      if (cur_slot != banked_regs_pkg::SLOT_NONE) begin
        rd_val = saved_q[cur_slot];
      end
    end else if (gpr_rd) begin
      rd_val = gp_q[phys(mode, s_axi_araddr[5:2])];
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    wr_hit = gpr_wr;
    if (awaddr_q == banked_regs_pkg::OFF_CMD ||
        awaddr_q == banked_regs_pkg::OFF_OPERAND ||
        awaddr_q == banked_regs_pkg::OFF_FETCH ||
        awaddr_q == banked_regs_pkg::OFF_LANE_CTRL ||
        awaddr_q == banked_regs_pkg::OFF_LANE_DATA ||
        awaddr_q == banked_regs_pkg::OFF_CTRL ||
        awaddr_q == banked_regs_pkg::OFF_CUR_STATUS ||
        awaddr_q == banked_regs_pkg::OFF_SAVED_STATUS) begin
      wr_hit = 1'b1;
    end
  end

  // ************************************************************
  // Plain configuration registers
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operand_q <= 32'h0000_0000;
      fetch_q <= 32'h0000_0000;
      lane_data_q <= 32'h0000_0000;
      lane_ctrl_q <= 6'h00;
      big_endian_q <= 1'b0;
    end else if (clk_en && wr_fire) begin
      if (awaddr_q == banked_regs_pkg::OFF_OPERAND) begin
        operand_q <= merge(operand_q, wdata_q, wstrb_q);
      end else if (awaddr_q == banked_regs_pkg::OFF_FETCH) begin
        fetch_q <= merge(fetch_q, wdata_q, wstrb_q);
      end else if (awaddr_q == banked_regs_pkg::OFF_LANE_DATA) begin
        lane_data_q <= merge(lane_data_q, wdata_q, wstrb_q);
      end else if (awaddr_q == banked_regs_pkg::OFF_LANE_CTRL) begin
        if (wstrb_q[0]) begin
          lane_ctrl_q <= wdata_q[5:0];
        end
      end else if (awaddr_q == banked_regs_pkg::OFF_CTRL) begin
        if (wstrb_q[0]) begin
          big_endian_q <= wdata_q[0];
        end
      end
    end
  end

  // ************************************************************
  // Banked state and commands
  // ************************************************************
  logic is_cmd;
  logic [2:0] op;
  logic [4:0] tgt;
  logic [2:0] tgt_slot;
  assign is_cmd = wr_fire && awaddr_q == banked_regs_pkg::OFF_CMD;
  assign op = wdata_q[2:0];
  assign tgt = wdata_q[8:4];
  assign tgt_slot = slot(tgt);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < banked_regs_pkg::NUM_GP; k++) begin
        gp_q[k] <= 32'h0000_0000;
      end
      for (int k = 0; k < banked_regs_pkg::NUM_SAVED; k++) begin
        saved_q[k] <= 32'h0000_0000;
      end
      gp_q[15] <= banked_regs_pkg::PC_RST;
      cur_q <= banked_regs_pkg::STATUS_RST;
    end else if (clk_en) begin
      if (is_cmd && op == banked_regs_pkg::OP_BRANCH_LINK) begin
        gp_q[phys(mode, 4'd14)] <= pc;
        gp_q[15] <= operand_q;
      end else if (is_cmd && op == banked_regs_pkg::OP_BRANCH_EXCHANGE) begin
        // Only the state bit and the program counter move; mode and other registers stay put
        cur_q[banked_regs_pkg::STATE_BIT] <= operand_q[0];
        gp_q[15] <= {operand_q[31:1], 1'b0};
      end else if (is_cmd && op == banked_regs_pkg::OP_EXC_ENTRY &&
                   tgt_slot != banked_regs_pkg::SLOT_NONE) begin
        saved_q[tgt_slot] <= cur_q;
        gp_q[phys(tgt, 4'd14)] <= pc + step;
        cur_q <= {cur_q[31:6], 1'b0, tgt};
        gp_q[15] <= {operand_q[31:2], 2'b00};
      end else if (is_cmd && op == banked_regs_pkg::OP_EXC_RETURN &&
                   cur_slot != banked_regs_pkg::SLOT_NONE) begin
        cur_q <= saved_q[cur_slot];
        gp_q[15] <= saved_q[cur_slot][banked_regs_pkg::STATE_BIT] ?
          {gp_q[phys(mode, 4'd14)][31:1], 1'b0} :
          {gp_q[phys(mode, 4'd14)][31:2], 2'b00};
      end else if (wr_fire && gpr_wr) begin
        gp_q[phys(mode, awaddr_q[5:2])] <=
          merge(gp_q[phys(mode, awaddr_q[5:2])], wdata_q, wstrb_q);
      end else if (wr_fire && awaddr_q == banked_regs_pkg::OFF_CUR_STATUS &&
                   priv && mode_ok(wdata_q[4:0])) begin
        // Illegal mode codes are refused so the core cannot lock up
        cur_q <= merge(cur_q, wdata_q, wstrb_q);
      end else if (wr_fire && awaddr_q == banked_regs_pkg::OFF_SAVED_STATUS &&
                   cur_slot != banked_regs_pkg::SLOT_NONE) begin
        saved_q[cur_slot] <= merge(saved_q[cur_slot], wdata_q, wstrb_q);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_indicator_output <= 1'b0;
    end else if (clk_en) begin
      state_indicator_output <= t_bit;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_LINK_COPY: assert property (clk_en && is_cmd &&
    op == banked_regs_pkg::OP_BRANCH_LINK |=>
    gp_q[phys(mode, 4'd14)] == $past(pc))
    else $error("link register missed the program counter");
  AST_ENTRY_FULL: assert property (clk_en && is_cmd &&
    op == banked_regs_pkg::OP_EXC_ENTRY && tgt_slot != 3'h7 |=>
    !t_bit && mode == $past(tgt))
    else $error("exception entry not in full-width state");
  AST_ENTRY_SAVE: assert property (clk_en && is_cmd &&
    op == banked_regs_pkg::OP_EXC_ENTRY && tgt_slot != 3'h7 |=>
    saved_q[$past(tgt_slot)] == $past(cur_q))
    else $error("saved status not captured");
  AST_ENTRY_RET: assert property (clk_en && is_cmd &&
    op == banked_regs_pkg::OP_EXC_ENTRY && tgt_slot != 3'h7 |=>
    gp_q[phys(mode, 4'd14)] == $past(pc) + $past(step))
    else $error("return address wrong");
  AST_RETURN: assert property (clk_en && is_cmd &&
    op == banked_regs_pkg::OP_EXC_RETURN && cur_slot != 3'h7 |=>
    cur_q == $past(saved_q[cur_slot]))
    else $error("status not restored on return");
  AST_EXCH_MODE: assert property (clk_en && is_cmd &&
    op == banked_regs_pkg::OP_BRANCH_EXCHANGE |=>
    $stable(mode) && t_bit == $past(operand_q[0]))
    else $error("state change disturbed mode");
  AST_MIRROR: assert property ($past(clk_en) |->
    state_indicator_output == $past(t_bit))
    else $error("state output does not follow state bit");
  AST_LANE_LE: assert property (!big_endian_q &&
    lane_size == banked_regs_pkg::SIZE_BYTE && lane_off == 2'd0 |->
    lane_bus[7:0] == lane_data_q[7:0])
    else $error("little-endian byte 0 misplaced");
  AST_LANE_BE: assert property (big_endian_q &&
    lane_size == banked_regs_pkg::SIZE_BYTE && lane_off == 2'd0 |->
    lane_bus[31:24] == lane_data_q[7:0])
    else $error("big-endian byte 0 misplaced");
  AST_SAVED_PRIV: assert property (clk_en && s_axi_arvalid &&
    s_axi_arready && s_axi_araddr == banked_regs_pkg::OFF_SAVED_STATUS &&
    cur_slot == 3'h7 |=> s_axi_rdata == 32'h0000_0000)
    else $error("saved status leaked outside privileged modes");
  AST_WR_RESP: assert property (clk_en && wr_fire |=> s_axi_bvalid)
    else $error("write response missing");

  COV_FAST: cover property (mode == banked_regs_pkg::MODE_FAST &&
    wr_fire && gpr_wr);
  COV_ENTRY_COMPACT: cover property (t_bit && is_cmd &&
    op == banked_regs_pkg::OP_EXC_ENTRY);
  COV_RETURN_COMPACT: cover property (is_cmd &&
    op == banked_regs_pkg::OP_EXC_RETURN ##1 t_bit);
endmodule

/* dv/tb_banked_register_file.sv */
`timescale 1ns/1ps
module tb_banked_register_file;
  // ********
  // Bus signals and model state
  // ********
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic clk_en = 1'h1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, ind;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rx, v, pc, st, sv;
  logic [31:0] seed = 32'h1caf_8c61;
  // Physical copies: 0-14 shared, 15-21 fast, 22-29 pairs
  logic [31:0] phys [0:29];
  logic [4:0] ml [0:5];
  int fail_count = 0;
  int total_checks = 0;
  always #12.5 aclk = ~aclk;
  banked_register_file dut (.aclk(aclk), .aresetn(aresetn),
    .clk_en(clk_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .state_indicator_output(ind));
  // ********
  // Helpers
  // ********
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function int pidx(input logic [4:0] m, input int i);
    if (m == banked_regs_pkg::MODE_FAST && i >= 8) return i + 7;
    if (i < 13) return i;
    case (m)
      banked_regs_pkg::MODE_NORM: return i + 9;
      banked_regs_pkg::MODE_SUPV: return i + 11;
      banked_regs_pkg::MODE_ABRT: return i + 13;
      banked_regs_pkg::MODE_UNDF: return i + 15;
      default: return i;
    endcase
  endfunction
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    if (n == 64) begin
      fail_count++;
      test_done();
    end
    resp = bresp;
    bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    if (n == 64) begin
      fail_count++;
      test_done();
    end
    rx = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask
  task setm(input logic [4:0] m);
    st = {27'h0, m};
    wr(banked_regs_pkg::OFF_CUR_STATUS, st);
  endtask
  task cmd(input logic [2:0] op, input logic [4:0] m, input logic [31:0] d);
    wr(banked_regs_pkg::OFF_OPERAND, d);
    wr(banked_regs_pkg::OFF_CMD, {23'h0, m, 1'h0, op});
  endtask
  task gpr(input int i);
    rd(banked_regs_pkg::OFF_GPR_BASE + 8'(4 * i));
  endtask
  initial begin
    int i, k;
    ml = '{banked_regs_pkg::MODE_SUPV, banked_regs_pkg::MODE_FAST,
      banked_regs_pkg::MODE_NORM, banked_regs_pkg::MODE_ABRT,
      banked_regs_pkg::MODE_UNDF, banked_regs_pkg::MODE_SYST};
    pc = banked_regs_pkg::PC_RST;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rd(banked_regs_pkg::OFF_CUR_STATUS);
    chk("status", rx, banked_regs_pkg::STATUS_RST);
    chk("state_out", {31'h0, ind}, 32'h0);
    $display("test reset done");
    for (k = 0; k < 6; k++) begin
      setm(ml[k]);
      for (i = 0; i < 15; i++) begin
        v = rnd();
        wr(banked_regs_pkg::OFF_GPR_BASE + 8'(4 * i), v);
        phys[pidx(ml[k], i)] = v;
      end
    end
    setm(banked_regs_pkg::MODE_SUPV);
    v = rnd() & 32'hffff_fffc;
    cmd(banked_regs_pkg::OP_BRANCH_LINK, 5'h0, v);
    phys[pidx(banked_regs_pkg::MODE_SUPV, 14)] = pc;
    pc = v;
    gpr(14);
    chk("link", rx, phys[pidx(banked_regs_pkg::MODE_SUPV, 14)]);
    v = rnd() | 32'h1;
    cmd(banked_regs_pkg::OP_BRANCH_EXCHANGE, 5'h0, v);
    pc = v & 32'hffff_fffe;
    st = st | 32'h20;
    rd(banked_regs_pkg::OFF_CUR_STATUS);
    chk("status", rx, st);
    chk("state_out", {31'h0, ind}, 32'h1);
    v = rnd();
    cmd(banked_regs_pkg::OP_EXC_ENTRY, banked_regs_pkg::MODE_FAST, v);
    phys[21] = pc + banked_regs_pkg::STEP_COMPACT;
    sv = st;
    st = {27'h0, banked_regs_pkg::MODE_FAST};
    pc = v & 32'hffff_fffc;
    rd(banked_regs_pkg::OFF_CUR_STATUS);
    chk("status", rx, st);
    chk("state_out", {31'h0, ind}, 32'h0);
    rd(banked_regs_pkg::OFF_SAVED_STATUS);
    chk("saved", rx, sv);
    gpr(14);
    chk("link", rx, phys[21]);
    cmd(banked_regs_pkg::OP_EXC_RETURN, 5'h0, 32'h0);
    st = sv;
    pc = phys[21] & 32'hffff_fffe;
    rd(banked_regs_pkg::OFF_CUR_STATUS);
    chk("status", rx, st);
    chk("state_out", {31'h0, ind}, 32'h1);
    gpr(15);
    chk("pc", rx, pc);
    $display("test branch and exception done");
    // First pass stays compact: contents must survive the state change
    for (k = 0; k < 6; k++) begin
      if (k > 0) setm(ml[k]);
      for (i = 0; i < 15; i++) begin
        gpr(i);
        chk("gpr", rx, phys[pidx(ml[k], i)]);
      end
      rd(banked_regs_pkg::OFF_STATUS);
      chk("priv", {31'h0, rx[1]}, 32'h1);
      rd(banked_regs_pkg::OFF_SAVED_STATUS);
      chk("saved", rx, (k == 1) ? sv : 32'h0);
    end
    $display("test banking done");
    v = rnd();
    wr(banked_regs_pkg::OFF_FETCH, v);
    rd(banked_regs_pkg::OFF_INSN);
    chk("insn", rx, v);
    for (k = 0; k < 4; k++) begin
      wr(banked_regs_pkg::OFF_CTRL, {31'h0, k[1]});
      cmd(banked_regs_pkg::OP_BRANCH_EXCHANGE, 5'h0, {30'h0, k[0], 1'h1});
      rd(banked_regs_pkg::OFF_INSN);
      chk("insn", rx, (k[0] ^ k[1]) ? v >> 16 : v & 32'hffff);
    end
    $display("test halfword select done");
    // Every size and offset in both byte orders, misaligned ones too
    v = rnd();
    wr(banked_regs_pkg::OFF_LANE_DATA, v);
    for (k = 0; k < 24; k++) begin
      i = k / 4 % 3;
      wr(banked_regs_pkg::OFF_CTRL, 32'(k / 12));
      wr(banked_regs_pkg::OFF_LANE_CTRL, 32'(i * 16 + k % 4));
      rd(banked_regs_pkg::OFF_LANE_BUS);
      if (i == 0)
        sv = (v & 32'hff) << (8 * ((k >= 12) ? 3 - k % 4 : k % 4));
      else if (i == 1)
        sv = (v & 32'hffff) << (16 * ((k >= 12) ? 1 - k % 4 / 2 : k % 4 / 2));
      else
        sv = v;
      chk("lane_bus", rx, sv);
      pc = 32'((i == 2 && k % 4 != 0) || (i == 1 && k % 2 == 1));
      rd(banked_regs_pkg::OFF_STATUS);
      chk("misaligned", {31'h0, rx[0]}, pc);
    end
    $display("test byte lanes done");
    rd(8'h30);
    chk("rresp", {30'h0, resp}, {30'h0, banked_regs_pkg::RESP_SLVERR});
    chk("rdata", rx, 32'h0);
    wr(8'h30, v);
    chk("bresp", {30'h0, resp}, {30'h0, banked_regs_pkg::RESP_SLVERR});
    setm(banked_regs_pkg::MODE_USER);
    wr(banked_regs_pkg::OFF_CUR_STATUS, banked_regs_pkg::STATUS_RST);
    rd(banked_regs_pkg::OFF_CUR_STATUS);
    chk("status", rx, st);
    rd(banked_regs_pkg::OFF_STATUS);
    chk("priv", {31'h0, rx[1]}, 32'h0);
    rd(banked_regs_pkg::OFF_SAVED_STATUS);
    chk("saved", rx, 32'h0);
    $display("test user mode done");
    test_done();
  end
endmodule
